// ===== core/spcs_regs.vh
// Register map, field positions, reset values and timing counts of the serial port
// Behaviour
// - tx_empty_irq_en gates buffer-empty interrupt request
// - tx_done_irq_en gates transmission-complete interrupt request
// - rx_full_irq_en gates receive-full and overrun requests
// - line_quiet_irq_en gates idle-line interrupt request
// - tx_on enables transmitter, takes transmit pin
// - Rising tx_on queues one idle preamble
// - rx_on enables the receiver
// - rx_sleep arms wakeup, masks receiver requests
// - Wakeup condition clears rx_sleep by hardware
// - Toggled break_send sends one full break
// - Held break_send repeats whole break characters
// - Flags clear by status read, then data access
// - Status one ignores writes, always readable
// - tx_buf_empty sets when shifter takes data
// - tx_buf_empty clears on armed data-low write
// - tx_done_flag low while anything is sending
// - Transmit pin idles high while done
// - tx_done_flag clears by sequence or queueing
// - Simultaneous set and clear: clear wins for tx_done_flag, set wins for the other flags
// - Idle flag after 10 or 11 ones
// - No idle flag while rx_sleep set
// - Baud generator off until enabled, divisor nonzero
// - Nine-bit select sets frame, break, idle lengths
`ifndef SPCS_REGS_VH
`define SPCS_REGS_VH

`define SPCS_OFF_BAUD_HI   3'h0
`define SPCS_OFF_BAUD_LO   3'h1
`define SPCS_OFF_CTL_ONE   3'h2
`define SPCS_OFF_CTL_TWO   3'h3
`define SPCS_OFF_STAT_ONE  3'h4
`define SPCS_OFF_STAT_TWO  3'h5
`define SPCS_OFF_DATA_HI   3'h6
`define SPCS_OFF_DATA_LO   3'h7

`define SPCS_C2_TX_EMPTY_IE 7
`define SPCS_C2_TX_DONE_IE  6
`define SPCS_C2_RX_FULL_IE  5
`define SPCS_C2_QUIET_IE    4
`define SPCS_C2_TX_ON       3
`define SPCS_C2_RX_ON       2
`define SPCS_C2_RX_SLEEP    1
`define SPCS_C2_BREAK_SEND  0

`define SPCS_C1_LOOP        7
`define SPCS_C1_NINE_BIT    4
`define SPCS_C1_WAKE_ADDR   3

`define SPCS_S2_LONG_BREAK  2
`define SPCS_S2_RX_ACTIVE   0

`define SPCS_DH_RX_BIT8     7
`define SPCS_DH_TX_BIT8     6

`define SPCS_BAUD_RST       13'h0004
`define SPCS_CTL_RST        8'h00

`define SPCS_MID_TICK       4'h7
`define SPCS_LAST_TICK      4'hf
`define SPCS_FRAME_EIGHT    4'ha
`define SPCS_FRAME_NINE     4'hb
`define SPCS_LONG_BRK_EXTRA 4'h3

`endif

// ===== core/spcs_top.v
// Serial port control, transmit status, baud, transmitter and receiver
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "spcs_regs.vh"

module spcs_top (
	input  wire       REF_CLK,
	input  wire       SYS_RST,
	input  wire [2:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR_STB,
	input  wire       RD_STB,
	output wire [7:0] RDATA,
	input  wire       RXD_IN,
	output wire       TXD_OUT,
	output wire       TXD_OE,
	output wire       IRQ
);

	localparam TX_IDLE  = 1'b0;
	localparam TX_SEND  = 1'b1;
	localparam RX_IDLE  = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA  = 2'd2;

	reg  [4:0]  baud_tmp_reg;
	reg  [12:0] baud_div_reg;
	reg  [7:0]  ctl_one_reg;
	reg  [7:0]  ctl_two_reg;
	reg         long_break_reg;
	reg  [7:0]  tx_data_reg;
	reg         tx_bit8_reg;
	reg  [7:0]  rx_data_reg;
	reg         rx_bit8_reg;
	reg  [7:0]  rdata_reg;
	reg  [7:0]  arm_reg;
	reg         baud_started_reg;
	reg  [12:0] baud_cnt_reg;
	reg         tick_reg;
	reg  [3:0]  tx_sub_reg;
	reg         tx_state_reg;
	reg  [13:0] tx_shift_reg;
	reg  [3:0]  tx_cnt_reg;
	reg         tx_line_reg;
	reg         tx_pend_reg;
	reg         pre_pend_reg;
	reg         tx_empty_reg;
	reg         tx_done_reg;
	reg  [1:0]  rx_state_reg;
	reg  [3:0]  rx_sub_reg;
	reg  [3:0]  rx_cnt_reg;
	reg  [8:0]  rx_shift_reg;
	reg         rx_full_reg;
	reg         quiet_reg;
	reg         overrun_reg;
	reg         frame_err_reg;
	reg         quiet_armed_reg;
	reg  [7:0]  quiet_cnt_reg;
	reg         rx_meta_reg;
	reg         rx_sync_reg;
	reg         irq_reg;

	wire        wr_ctl_two  = WR_STB && (ADDR == `SPCS_OFF_CTL_TWO);
	wire        wr_data_lo  = WR_STB && (ADDR == `SPCS_OFF_DATA_LO);
	wire        rd_data_lo  = RD_STB && (ADDR == `SPCS_OFF_DATA_LO);
	wire        rd_stat_one = RD_STB && (ADDR == `SPCS_OFF_STAT_ONE);
	wire        tx_on       = ctl_two_reg[`SPCS_C2_TX_ON];
	wire        rx_on       = ctl_two_reg[`SPCS_C2_RX_ON];
	wire        rx_sleep    = ctl_two_reg[`SPCS_C2_RX_SLEEP];
	wire        break_send  = ctl_two_reg[`SPCS_C2_BREAK_SEND];
	wire        nine_bit    = ctl_one_reg[`SPCS_C1_NINE_BIT];
	wire        wake_addr   = ctl_one_reg[`SPCS_C1_WAKE_ADDR];
	wire [3:0]  frame_len   = nine_bit ? `SPCS_FRAME_NINE : `SPCS_FRAME_EIGHT;
	wire [3:0]  break_len   = long_break_reg ? frame_len + `SPCS_LONG_BRK_EXTRA : frame_len;
	wire [7:0]  quiet_len   = {frame_len, 4'h0};
	wire [7:0]  status_one  = {tx_empty_reg, tx_done_reg, rx_full_reg, quiet_reg,
	                           overrun_reg, 1'b0, frame_err_reg, 1'b0};
	wire        rx_in       = ctl_one_reg[`SPCS_C1_LOOP] ? tx_line_reg : rx_sync_reg;
	wire        bit_tick    = tick_reg && (tx_sub_reg == `SPCS_LAST_TICK);
	wire        tx_enter    = wr_ctl_two && WDATA[`SPCS_C2_TX_ON] && !tx_on;
	wire        tx_load     = (tx_state_reg == TX_IDLE) && bit_tick && tx_on &&
	                          (pre_pend_reg || break_send || tx_pend_reg);
	wire        load_data   = tx_load && !pre_pend_reg && !break_send;
	wire        brk_again   = (tx_state_reg == TX_SEND) && bit_tick &&
	                          (tx_cnt_reg == 4'h0) && break_send && tx_on;
	wire        rx_done     = tick_reg && (rx_state_reg == RX_DATA) &&
	                          (rx_sub_reg == `SPCS_LAST_TICK) && (rx_cnt_reg == frame_len - 4'h2);
	wire        addr_wake   = rx_sleep && wake_addr && rx_shift_reg[8];
	wire        rx_accept   = rx_done && (!rx_sleep || addr_wake);
	wire        quiet_hit   = tick_reg && rx_on && rx_in && (quiet_cnt_reg == quiet_len - 8'h1);
	wire        sleep_clr   = (rx_done && addr_wake) ||
	                          (quiet_hit && rx_sleep && !wake_addr);

	// Pin input synchroniser
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= RXD_IN;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// Software-written registers
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			baud_tmp_reg   <= 5'h00;
			baud_div_reg   <= `SPCS_BAUD_RST;
			ctl_one_reg    <= `SPCS_CTL_RST;
			ctl_two_reg    <= `SPCS_CTL_RST;
			long_break_reg <= 1'b0;
			tx_data_reg    <= 8'h00;
			tx_bit8_reg    <= 1'b0;
		end else begin
			if (WR_STB) begin
				case (ADDR)
				`SPCS_OFF_BAUD_HI: baud_tmp_reg <= WDATA[4:0];
				`SPCS_OFF_BAUD_LO: baud_div_reg <= {baud_tmp_reg, WDATA};
				`SPCS_OFF_CTL_ONE: ctl_one_reg <= WDATA;
				`SPCS_OFF_STAT_TWO: long_break_reg <= WDATA[`SPCS_S2_LONG_BREAK];
				`SPCS_OFF_DATA_HI: tx_bit8_reg <= WDATA[`SPCS_DH_TX_BIT8];
				`SPCS_OFF_DATA_LO: tx_data_reg <= WDATA;
				default: ; // Status one ignores writes
				endcase
			end
			// Control two, with hardware wakeup on rx_sleep
			if (wr_ctl_two) begin
				ctl_two_reg <= WDATA;
			end else if (sleep_clr) begin
				ctl_two_reg[`SPCS_C2_RX_SLEEP] <= 1'b0;
			end
		end
	end

	// Register read, data valid the cycle after the strobe
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_reg <= 8'h00;
		end else if (RD_STB) begin
			case (ADDR)
			`SPCS_OFF_BAUD_HI: rdata_reg <= {3'h0, baud_div_reg[12:8]};
			`SPCS_OFF_BAUD_LO: rdata_reg <= baud_div_reg[7:0];
			`SPCS_OFF_CTL_ONE: rdata_reg <= ctl_one_reg;
			`SPCS_OFF_CTL_TWO: rdata_reg <= ctl_two_reg;
			`SPCS_OFF_STAT_ONE: rdata_reg <= status_one;
			`SPCS_OFF_STAT_TWO: rdata_reg <= {5'h00, long_break_reg, 1'b0,
			                                  rx_state_reg != RX_IDLE};
			`SPCS_OFF_DATA_HI: rdata_reg <= {rx_bit8_reg, tx_bit8_reg, 6'h00};
			`SPCS_OFF_DATA_LO: rdata_reg <= rx_data_reg;
			default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// Clear arming: status read snapshots the set flags
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			arm_reg <= 8'h00;
		end else if (rd_stat_one) begin
			arm_reg <= status_one;
		end else if (wr_data_lo) begin
			arm_reg <= {2'b00, arm_reg[5:0]};
		end else if (rd_data_lo) begin
			arm_reg <= {arm_reg[7:6], 6'h00};
		end
	end

	// Baud generator, sixteen ticks per bit
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			baud_started_reg <= 1'b0;
			baud_cnt_reg     <= 13'h0000;
			tick_reg         <= 1'b0;
		end else begin
			if (tx_on || rx_on) begin
				baud_started_reg <= 1'b1;
			end
			if (!baud_started_reg || (baud_div_reg == 13'h0000)) begin
				baud_cnt_reg <= 13'h0000;
				tick_reg     <= 1'b0;
			end else if (baud_cnt_reg >= baud_div_reg - 13'h0001) begin
				baud_cnt_reg <= 13'h0000;
				tick_reg     <= 1'b1;
			end else begin
				baud_cnt_reg <= baud_cnt_reg + 13'h0001;
				tick_reg     <= 1'b0;
			end
		end
	end

	// Transmit queue: data, preamble and pending flags
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_pend_reg  <= 1'b0;
			pre_pend_reg <= 1'b0;
			tx_empty_reg <= 1'b1;
		end else begin
			if (wr_data_lo) begin
				tx_pend_reg <= 1'b1;
			end else if (load_data) begin
				tx_pend_reg <= 1'b0;
			end
			if (tx_enter) begin
				pre_pend_reg <= 1'b1;
			end else if (tx_load) begin
				pre_pend_reg <= 1'b0;
			end
			if (load_data) begin
				tx_empty_reg <= 1'b1;
			end else if (wr_data_lo && arm_reg[7]) begin
				tx_empty_reg <= 1'b0;
			end
		end
	end

	// Transmission complete: clearing wins over setting
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_done_reg <= 1'b1;
		end else if ((wr_data_lo && arm_reg[6]) || wr_data_lo || tx_enter ||
		             (wr_ctl_two && WDATA[`SPCS_C2_BREAK_SEND]) || tx_load) begin
			tx_done_reg <= 1'b0;
		end else if ((tx_state_reg == TX_IDLE) && tx_empty_reg && !tx_pend_reg &&
		             !pre_pend_reg && !break_send) begin
			tx_done_reg <= 1'b1;
		end
	end

	// Transmit shifter: data frames, preambles and breaks
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_sub_reg   <= 4'h0;
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= 14'h3fff;
			tx_cnt_reg   <= 4'h0;
			tx_line_reg  <= 1'b1;
		end else begin
			if (tick_reg) begin
				tx_sub_reg <= tx_sub_reg + 4'h1;
			end
			case (tx_state_reg)
			TX_IDLE: begin
				tx_line_reg <= 1'b1;
				if (tx_load) begin
					tx_state_reg <= TX_SEND;
					if (pre_pend_reg) begin
						tx_shift_reg <= 14'h3fff;
						tx_cnt_reg   <= frame_len;
					end else if (break_send) begin
						tx_shift_reg <= 14'h0000;
						tx_cnt_reg   <= break_len;
					end else begin
						tx_shift_reg <= {4'hf, nine_bit ? tx_bit8_reg : 1'b1,
						                 tx_data_reg, 1'b0};
						tx_cnt_reg   <= frame_len;
					end
				end
			end
			TX_SEND: begin
				if (bit_tick) begin
					// Last bit holds a full bit time before reload or idle
					if (tx_cnt_reg != 4'h0) begin
						tx_line_reg  <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[13:1]};
						tx_cnt_reg   <= tx_cnt_reg - 4'h1;
					end else if (brk_again) begin
						tx_line_reg  <= 1'b0;
						tx_shift_reg <= 14'h2000;
						tx_cnt_reg   <= break_len - 4'h1;
					end else begin
						tx_line_reg  <= 1'b1;
						tx_state_reg <= TX_IDLE;
					end
				end
			end
			default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// Receiver: start detect, mid-bit sampling, stop check
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_state_reg <= RX_IDLE;
			rx_sub_reg   <= 4'h0;
			rx_cnt_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
		end else if (!rx_on) begin
			rx_state_reg <= RX_IDLE;
		end else if (tick_reg) begin
			rx_sub_reg <= rx_sub_reg + 4'h1;
			case (rx_state_reg)
			RX_IDLE: begin
				rx_sub_reg <= 4'h0;
				if (!rx_in) begin
					rx_state_reg <= RX_START;
				end
			end
			RX_START: begin
				if (rx_sub_reg == `SPCS_MID_TICK) begin
					rx_sub_reg   <= 4'h0;
					rx_cnt_reg   <= 4'h0;
					rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_sub_reg == `SPCS_LAST_TICK) begin
					if (rx_done) begin
						rx_state_reg <= RX_IDLE;
					end else begin
						rx_shift_reg <= {rx_in, rx_shift_reg[8:1]};
						rx_cnt_reg   <= rx_cnt_reg + 4'h1;
					end
				end
			end
			default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// Receive flags and data; a set wins over a clear
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_full_reg     <= 1'b0;
			overrun_reg     <= 1'b0;
			frame_err_reg   <= 1'b0;
			rx_data_reg     <= 8'h00;
			rx_bit8_reg     <= 1'b0;
			quiet_reg       <= 1'b0;
			quiet_armed_reg <= 1'b0;
		end else begin
			if (rx_accept && !rx_full_reg) begin
				rx_full_reg   <= 1'b1;
				rx_data_reg   <= nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
				rx_bit8_reg   <= nine_bit & rx_shift_reg[8];
				frame_err_reg <= !rx_in;
			end else if (rd_data_lo) begin
				rx_full_reg   <= rx_full_reg & !arm_reg[5];
				frame_err_reg <= frame_err_reg & !arm_reg[1];
			end
			if (rx_accept && rx_full_reg) begin
				overrun_reg <= 1'b1;
			end else if (rd_data_lo && arm_reg[3]) begin
				overrun_reg <= 1'b0;
			end
			if (quiet_hit && quiet_armed_reg && !rx_sleep) begin
				quiet_reg <= 1'b1;
			end else if (rd_data_lo && arm_reg[4]) begin
				quiet_reg <= 1'b0;
			end
			if (rx_accept && !rx_full_reg) begin
				quiet_armed_reg <= 1'b1;
			end else if (quiet_hit && !rx_sleep) begin
				quiet_armed_reg <= 1'b0;
			end
		end
	end

	// Idle line counter in ticks of consecutive ones
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			quiet_cnt_reg <= 8'h00;
		end else if (!rx_on || !rx_in) begin
			quiet_cnt_reg <= 8'h00;
		end else if (tick_reg && (quiet_cnt_reg < quiet_len)) begin
			quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
		end
	end

	// Interrupt request from enabled flags
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (tx_empty_reg & ctl_two_reg[`SPCS_C2_TX_EMPTY_IE]) |
			           (tx_done_reg & ctl_two_reg[`SPCS_C2_TX_DONE_IE]) |
			           ((rx_full_reg | overrun_reg) & !rx_sleep &
			            ctl_two_reg[`SPCS_C2_RX_FULL_IE]) |
			           (quiet_reg & !rx_sleep & ctl_two_reg[`SPCS_C2_QUIET_IE]);
		end
	end

	// Outputs
	assign RDATA   = rdata_reg;
	assign TXD_OUT = tx_line_reg;
	assign TXD_OE  = tx_on || (tx_state_reg == TX_SEND);
	assign IRQ     = irq_reg;

endmodule // spcs_top

// ===== test/spcs_props.sv
// Port-level assertions for the serial port control block
`timescale 1ns/1ns
module spcs_props (
	input wire       REF_CLK,
	input wire       SYS_RST,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR_STB,
	input wire       RD_STB,
	input wire [7:0] RDATA,
	input wire       RXD_IN,
	input wire       TXD_OUT,
	input wire       TXD_OE,
	input wire       IRQ
);
	reg  [7:0] ctl_reg;
	wire       st_rd = RD_STB && ADDR == 3'h4;
	wire       c2_wr = WR_STB && ADDR == 3'h3;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// Shadow of control_two as software wrote it
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			ctl_reg <= 8'h00;
		else if (c2_wr)
			ctl_reg <= WDATA;
	end
	property p_rd_idle; !$past(RD_STB) |-> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_ctl_back;
		RD_STB && ADDR == 3'h3 |=> {RDATA[7:2], RDATA[0]} == {ctl_reg[7:2], ctl_reg[0]};
	endproperty
	a_ctl_back: assert property (p_ctl_back) else $error("control readback");
	property p_oe_on; c2_wr && WDATA[3] |=> TXD_OE; endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not taken");
	property p_done_idle; st_rd ##1 RDATA[6] |-> $past(TXD_OUT); endproperty
	a_done_idle: assert property (p_done_idle) else $error("line not idle");
	property p_done_empty; st_rd ##1 RDATA[6] |-> RDATA[7]; endproperty
	a_done_empty: assert property (p_done_empty) else $error("done without empty");
	property p_irq_en; IRQ |-> $past(ctl_reg[7:4]) != 4'h0; endproperty
	a_irq_en: assert property (p_irq_en) else $error("request not enabled");
	property p_txon_done;
		c2_wr && WDATA[3] && !ctl_reg[3] ##[1:2] st_rd |=> !RDATA[6];
	endproperty
	a_txon_done: assert property (p_txon_done) else $error("preamble left done");
	property p_brk_done; c2_wr && WDATA[0] && WDATA[3] ##[1:2] st_rd |=> !RDATA[6]; endproperty
	a_brk_done: assert property (p_brk_done) else $error("break left done");
	// Main scenarios reached
	c_done: cover property (st_rd ##1 RDATA[6]);
	c_irq: cover property ($rose(IRQ));
	c_brk: cover property (c2_wr && WDATA[0]);
endmodule // spcs_props
bind spcs_top spcs_props u_props (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .RXD_IN(RXD_IN),
	.TXD_OUT(TXD_OUT), .TXD_OE(TXD_OE), .IRQ(IRQ));

// ===== test/spcs_remote.sv
// Remote serial device on the transmit and receive pins
`timescale 1ns/1ns
module spcs_remote #(parameter int BIT = 16) (
	input  wire  clk,
	input  wire  txd,
	output logic rxd
);
	int         run, lo_len, n_brk, n_rx, j;
	logic [7:0] sh, rx_byte;
	logic [9:0] frm;
	initial rxd = 1'b1;
	// Send one frame, start low, LSB first, stop high
	task send(input logic [7:0] b);
		frm = {1'b1, b, 1'b0};
		for (j = 0; j < 10; j++) begin
			rxd <= frm[j];
			repeat (BIT) @(posedge clk);
		end
	endtask
	// Measure low runs, long ones are breaks
	always @(negedge clk) begin
		if (!txd)
			run <= run + 1;
		else begin
			if (run >= 10 * BIT) begin
				lo_len <= run;
				n_brk <= n_brk + 1;
			end
			run <= 0;
		end
	end
	// Decode eight-bit frames, a low stop bit is dropped
	initial forever begin
		@(negedge clk);
		while (txd) @(negedge clk);
		repeat (BIT / 2) @(negedge clk);
		for (int k = 0; k < 9; k++) begin
			repeat (BIT) @(negedge clk);
			if (k < 8)
				sh[k] = txd;
		end
		if (txd) begin
			rx_byte = sh;
			n_rx++;
		end
		while (!txd) @(negedge clk);
	end
endmodule // spcs_remote

// ===== test/serial_port_control_status_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ns
module serial_port_control_status_bench;
	localparam int BIT = 16;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	wire  [7:0]  rdata;
	wire         rxd, txd, txd_oe, irq;
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          g, k, n;
	logic [31:0] seed = 32'he7885ebc;
	logic [7:0]  b, d;
	logic [7:0]  ie_v [5] = '{8'h88, 8'h48, 8'h28, 8'h18, 8'h08};
	spcs_top dut (.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .RXD_IN(rxd),
		.TXD_OUT(txd), .TXD_OE(txd_oe), .IRQ(irq));
	spcs_remote #(.BIT(BIT)) rem (.clk(clk), .txd(txd), .rxd(rxd));
	always #5 clk = ~clk;
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results;
		end
	end
	function logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function logic [15:0] brk_len(input logic nine, input logic lng);
		return 16'((10 + nine + (lng ? 3 : 0)) * BIT);
	endfunction
	task results;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [2:0] a, output logic [7:0] v);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask
	task rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		cmp({8'h00, v & m}, {8'h00, e});
	endtask
	task irq_is(input logic e);
		@(negedge clk);
		cmp({15'h0, irq}, {15'h0, e});
		@(posedge clk);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		b = rnd();
		wr(3'h7, b);
		rdc(3'h4, 8'h80, 8'h80);
		rdc(3'h3, 8'hff, 8'h00);
		wr(3'h4, 8'h3f);
		rdc(3'h4, 8'hbf, 8'h80);
		wr(3'h7, b);
		rdc(3'h4, 8'h80, 8'h00);
		$display("test flag clearing done");
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h01);
		wr(3'h3, 8'h08);
		rdc(3'h4, 8'h40, 8'h00);
		for (k = 1; k <= 4; k++) begin
			for (g = 0; g < 3000 && rem.n_rx < k; g++) @(posedge clk);
			cmp(16'(rem.n_rx), 16'(k));
			cmp({8'h00, rem.rx_byte}, {8'h00, b});
			b = rnd();
			rd(3'h4, d);
			if (k < 4)
				wr(3'h7, b);
		end
		d = 8'h00;
		for (g = 0; g < 100 && !d[6]; g++) rd(3'h4, d);
		cmp({8'h00, d}, 16'h00c0);
		cmp({15'h0, txd}, 16'h1);
		$display("test transmit done");
		for (k = 0; k < 5; k++) begin
			wr(3'h3, ie_v[k]);
			irq_is(|ie_v[k][7:6]);
		end
		$display("test enables done");
		for (k = 0; k < 4; k++) begin
			wr(3'h2, {3'h0, k[0], 4'h0});
			wr(3'h5, {5'h0, k[1], 2'h0});
			wr(3'h3, 8'h09);
			rdc(3'h4, 8'h40, 8'h00);
			for (g = 0; g < 200 && txd; g++) @(posedge clk);
			cmp({15'h0, txd}, 16'h0);
			wr(3'h3, 8'h08);
			n = rem.n_brk;
			for (g = 0; g < 600 && rem.n_brk == n; g++) @(posedge clk);
			cmp(16'(rem.n_brk), 16'(n + 1));
			cmp(16'(rem.lo_len), brk_len(k[0], k[1]));
		end
		wr(3'h2, 8'h00);
		wr(3'h5, 8'h00);
		wr(3'h3, 8'h09);
		repeat (400) @(posedge clk);
		wr(3'h3, 8'h08);
		n = rem.n_brk;
		for (g = 0; g < 600 && rem.n_brk == n; g++) @(posedge clk);
		cmp(16'(rem.n_brk), 16'(n + 1));
		cmp(16'(rem.lo_len > 10 * BIT), 16'h1);
		cmp(16'(rem.lo_len % (10 * BIT)), 16'h0);
		$display("test break done");
		wr(3'h3, 8'h2c);
		b = rnd();
		rem.send(b);
		repeat (4) @(posedge clk);
		irq_is(1'b1);
		rdc(3'h4, 8'h20, 8'h20);
		rdc(3'h7, 8'hff, b);
		irq_is(1'b0);
		repeat (220) @(posedge clk);
		rdc(3'h4, 8'h10, 8'h10);
		wr(3'h3, 8'h1c);
		irq_is(1'b1);
		$display("test receive done");
		wr(3'h2, 8'h08);
		wr(3'h3, 8'h3e);
		rem.send(rnd() & 8'h7f);
		repeat (4) @(posedge clk);
		rdc(3'h3, 8'h02, 8'h02);
		irq_is(1'b0);
		b = rnd() | 8'h80;
		rem.send(b);
		repeat (4) @(posedge clk);
		rdc(3'h3, 8'h02, 8'h00);
		rdc(3'h4, 8'h20, 8'h20);
		rdc(3'h7, 8'hff, b);
		$display("test wakeup done");
		// Idle wakeup: a dropped frame, then an idle line clears sleep
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h2e);
		rem.send(rnd());
		repeat (4) @(posedge clk);
		rdc(3'h3, 8'h02, 8'h02);
		rdc(3'h4, 8'h20, 8'h00);
		repeat (200) @(posedge clk);
		rdc(3'h3, 8'h02, 8'h00);
		rdc(3'h4, 8'h10, 8'h00);
		$display("test idle wake done");
		results;
	end
endmodule // serial_port_control_status_bench
